/* pkg/ncsr_regs.vh */
// Operation
// - issue 85h destination, then confirm 10h
// - re-issue 00h before resuming data reads
// - copy-back source and destination share plane
// - random data input once, unless whole units
// - program whole page or whole units
// - 90h then address 00h, five ID bytes
// - read strobe toggles with latches low
`ifndef NCSR_REGS_VH
`define NCSR_REGS_VH

`define NCSR_CMD_READ0    8'h00
`define NCSR_CMD_CB_READ  8'h35
`define NCSR_CMD_CB_IN    8'h85
`define NCSR_CMD_SER_IN   8'h80
`define NCSR_CMD_CONFIRM  8'h10
`define NCSR_CMD_STATUS   8'h70
`define NCSR_CMD_ID       8'h90
`define NCSR_ID_ADDR      8'h00

`define NCSR_K_CMD        3'h0
`define NCSR_K_ADDR       3'h1
`define NCSR_K_DIN        3'h2
`define NCSR_K_DOUT       3'h3
`define NCSR_K_WAIT       3'h4

`define NCSR_A_CTRL       12'h000
`define NCSR_A_STAT       12'h004
`define NCSR_A_RDATA      12'h008
`define NCSR_A_CFG        12'h00C

`define NCSR_ST_BUSY      0
`define NCSR_ST_RB        1
`define NCSR_ST_PLANE     2
`define NCSR_ST_UNIT      3
`define NCSR_CFG_WP       0
`define NCSR_CFG_CE       1

`define NCSR_PLANE_IDX    3'h2
`define NCSR_PLANE_BIT    6
`define NCSR_UNIT_BYTES   10'd528
`define NCSR_CB_IN_LIMIT  2'h3

`define NCSR_T_CLK_NS     25
`define NCSR_T_WP_NS      12
`define NCSR_T_WH_NS      10
`define NCSR_T_WB_NS      100
`define NCSR_CYC(ns)      (((ns) + `NCSR_T_CLK_NS - 1) / `NCSR_T_CLK_NS)

`endif

/* src/ncsr_host.v */
`timescale 1ns/1ps
`include "ncsr_regs.vh"

module ncsr_host (
    // clock and reset
    input  wire        CLOCK,
    input  wire        RSTN,
    // apb slave
    input  wire        PSEL,
    input  wire        PENABLE,
    input  wire        PWRITE,
    input  wire [11:0] PADDR,
    input  wire [31:0] PWDATA,
    output wire [31:0] PRDATA,
    output wire        PREADY,
    output wire        PSLVERR,
    // flash bus
    output reg         CE_N,
    output reg         CLE,
    output reg         ALE,
    output reg         WE_N,
    output reg         RE_N,
    output reg         WP_N,
    output reg  [7:0]  IO_OUT,
    output reg         IO_OE,
    input  wire [7:0]  IO_IN,
    input  wire        RB
);

    localparam integer LOW_INT  = `NCSR_CYC(`NCSR_T_WP_NS);
    localparam integer HIGH_INT = `NCSR_CYC(`NCSR_T_WH_NS);
    localparam integer WB_INT   = `NCSR_CYC(`NCSR_T_WB_NS);
    localparam [2:0]   LOW_CYC  = LOW_INT[2:0];
    localparam [2:0]   HIGH_CYC = HIGH_INT[2:0];
    localparam [2:0]   WB_CYC   = WB_INT[2:0];

    localparam [4:0] S_IDLE = 5'h01;
    localparam [4:0] S_LOW  = 5'h02;
    localparam [4:0] S_HIGH = 5'h04;
    localparam [4:0] S_WB   = 5'h08;
    localparam [4:0] S_RB   = 5'h10;

    reg  [4:0] state;
    reg  [2:0] cnt;
    reg  [2:0] kind;
    reg  [7:0] byte_q;
    reg        redo;
    reg  [7:0] last_cmd;
    reg  [2:0] addr_idx;
    reg        status_mode;
    reg        page_out;
    reg        cb_active;
    reg        src_plane;
    reg  [1:0] cb_in_cnt;
    reg  [9:0] din_mod;
    reg        plane_err;
    reg        unit_err;
    reg  [7:0] rdata;
    reg        wp_cfg;
    reg        ce_cfg;

    wire acc     = PSEL & PENABLE;
    wire wr_ctrl = acc & PWRITE & (PADDR == `NCSR_A_CTRL);
    wire wr_stat = acc & PWRITE & (PADDR == `NCSR_A_STAT);
    wire wr_cfg  = acc & PWRITE & (PADDR == `NCSR_A_CFG);
    wire idle    = state[0];

    function mapped;
        input [11:0] a;
        begin
            mapped = (a == `NCSR_A_CTRL) | (a == `NCSR_A_STAT) |
                     (a == `NCSR_A_RDATA) | (a == `NCSR_A_CFG);
        end
    endfunction

    // a start while busy is refused with an error rather than queued
    assign PREADY  = 1'b1;
    assign PSLVERR = acc & (~mapped(PADDR) | (wr_ctrl & ~idle));
    assign PRDATA  = (PADDR == `NCSR_A_STAT) ?
                     {28'h0000000, unit_err, plane_err, RB, ~idle} :
                     (PADDR == `NCSR_A_RDATA) ? {24'h000000, rdata} :
                     (PADDR == `NCSR_A_CFG) ? {30'h00000000, ce_cfg, wp_cfg} :
                     32'h00000000;

    wire       start     = wr_ctrl & idle;
    wire [2:0] req_kind  = PWDATA[10:8];
    wire       need_fix  = (req_kind == `NCSR_K_DOUT) & status_mode & page_out;
    wire       id_addr   = (req_kind == `NCSR_K_ADDR) & (last_cmd == `NCSR_CMD_ID);
    wire       issue     = state[1] & (cnt == LOW_CYC - 3'h1);

    // sequencer
    always @(posedge CLOCK or negedge RSTN) begin
        if (!RSTN) begin
            state  <= S_IDLE;
            cnt    <= 3'h0;
            kind   <= `NCSR_K_CMD;
            byte_q <= 8'h00;
            redo   <= 1'b0;
            rdata  <= 8'h00;
        end else begin
            case (state)
                S_IDLE: begin
                    cnt <= 3'h0;
                    if (start) begin
                        if (need_fix) begin
                            kind   <= `NCSR_K_CMD;
                            byte_q <= `NCSR_CMD_READ0;
                            redo   <= 1'b1;
                            state  <= S_LOW;
                        end else begin
                            kind   <= req_kind;
                            byte_q <= id_addr ? `NCSR_ID_ADDR : PWDATA[7:0];
                            state  <= (req_kind == `NCSR_K_WAIT) ? S_WB : S_LOW;
                        end
                    end
                end
                S_LOW: begin
                    cnt <= cnt + 3'h1;
                    if (cnt == LOW_CYC - 3'h1) begin
                        cnt <= 3'h0;
                        state <= S_HIGH;
                    end
                end
                S_HIGH: begin
                    cnt <= cnt + 3'h1;
                    if (cnt == HIGH_CYC - 3'h1) begin
                        cnt <= 3'h0;
                        // sampled before the read strobe rises, data is still driven
                        if (kind == `NCSR_K_DOUT) begin
                            rdata <= IO_IN;
                        end
                        if (redo) begin
                            redo  <= 1'b0;
                            kind  <= `NCSR_K_DOUT;
                            state <= S_LOW;
                        end else if (kind == `NCSR_K_CMD || kind == `NCSR_K_WAIT) begin
                            // busy only shows after a short delay, so check late
                            state <= (kind == `NCSR_K_WAIT) ? S_RB : S_IDLE;
                        end else begin
                            state <= S_IDLE;
                        end
                    end
                end
                S_WB: begin
                    cnt <= cnt + 3'h1;
                    if (cnt == WB_CYC - 3'h1) begin
                        cnt   <= 3'h0;
                        state <= S_RB;
                    end
                end
                S_RB: begin
                    if (RB) begin
                        state <= S_IDLE;
                    end
                end
                default: begin
                    state <= S_IDLE;
                end
            endcase
        end
    end

    // pin drive, registered
    always @(posedge CLOCK or negedge RSTN) begin
        if (!RSTN) begin
            CE_N   <= 1'b1;
            CLE    <= 1'b0;
            ALE    <= 1'b0;
            WE_N   <= 1'b1;
            RE_N   <= 1'b1;
            WP_N   <= 1'b0;
            IO_OUT <= 8'h00;
            IO_OE  <= 1'b0;
        end else begin
            WP_N <= wp_cfg;
            CE_N <= ~(ce_cfg | ~idle);
            if (state[1]) begin
                CLE    <= (kind == `NCSR_K_CMD);
                ALE    <= (kind == `NCSR_K_ADDR);
                WE_N   <= (kind == `NCSR_K_DOUT);
                RE_N   <= (kind != `NCSR_K_DOUT);
                IO_OE  <= (kind != `NCSR_K_DOUT);
                IO_OUT <= redo ? `NCSR_CMD_READ0 : byte_q;
            end else begin
                WE_N <= 1'b1;
                RE_N <= 1'b1;
                if (idle) begin
                    CLE   <= 1'b0;
                    ALE   <= 1'b0;
                    IO_OE <= 1'b0;
                end
            end
        end
    end

    // command tracking and copy-back checks
    always @(posedge CLOCK or negedge RSTN) begin
        if (!RSTN) begin
            last_cmd    <= 8'h00;
            addr_idx    <= 3'h0;
            status_mode <= 1'b0;
            page_out    <= 1'b0;
            cb_active   <= 1'b0;
            src_plane   <= 1'b0;
            cb_in_cnt   <= 2'h0;
            din_mod     <= 10'h000;
            plane_err   <= 1'b0;
            unit_err    <= 1'b0;
            wp_cfg      <= 1'b0;
            ce_cfg      <= 1'b0;
        end else begin
            if (wr_cfg) begin
                wp_cfg <= PWDATA[`NCSR_CFG_WP];
                ce_cfg <= PWDATA[`NCSR_CFG_CE];
            end
            // write one to clear; a new event in the same cycle wins
            if (wr_stat && PWDATA[`NCSR_ST_PLANE]) begin
                plane_err <= 1'b0;
            end
            if (wr_stat && PWDATA[`NCSR_ST_UNIT]) begin
                unit_err <= 1'b0;
            end
            if (issue && kind == `NCSR_K_CMD) begin
                last_cmd    <= redo ? `NCSR_CMD_READ0 : byte_q;
                addr_idx    <= 3'h0;
                status_mode <= (byte_q == `NCSR_CMD_STATUS) & ~redo;
                if (redo) begin
                    status_mode <= 1'b0;
                end else if (byte_q == `NCSR_CMD_READ0 ||
                             byte_q == `NCSR_CMD_CB_READ) begin
                    page_out <= 1'b1;
                end else if (byte_q != `NCSR_CMD_STATUS) begin
                    page_out <= 1'b0;
                end
                if (!redo && byte_q == `NCSR_CMD_CB_READ) begin
                    cb_active <= 1'b1;
                    cb_in_cnt <= 2'h0;
                end
                if (!redo && (byte_q == `NCSR_CMD_CB_IN || byte_q == `NCSR_CMD_SER_IN)) begin
                    if (din_mod != 10'h000 && cb_in_cnt != 2'h0) begin
                        unit_err <= 1'b1;
                    end
                    if (byte_q == `NCSR_CMD_SER_IN) begin
                        din_mod <= 10'h000;
                    end
                    if (cb_in_cnt != `NCSR_CB_IN_LIMIT) begin
                        cb_in_cnt <= cb_in_cnt + 2'h1;
                    end
                end
                if (!redo && byte_q == `NCSR_CMD_CONFIRM) begin
                    if (din_mod != 10'h000) begin
                        unit_err <= 1'b1;
                    end
                    cb_active <= 1'b0;
                    cb_in_cnt <= 2'h0;
                    din_mod   <= 10'h000;
                end
            end
            if (issue && kind == `NCSR_K_ADDR) begin
                if (addr_idx != 3'h7) begin
                    addr_idx <= addr_idx + 3'h1;
                end
                if (addr_idx == `NCSR_PLANE_IDX) begin
                    // source address follows the 00h that precedes 35h
                    if (last_cmd == `NCSR_CMD_READ0) begin
                        src_plane <= byte_q[`NCSR_PLANE_BIT];
                    end
                    if (last_cmd == `NCSR_CMD_CB_IN && cb_active && cb_in_cnt == 2'h1 &&
                        byte_q[`NCSR_PLANE_BIT] != src_plane) begin
                        plane_err <= 1'b1;
                    end
                end
            end
            if (issue && kind == `NCSR_K_DIN) begin
                din_mod <= (din_mod == `NCSR_UNIT_BYTES - 10'd1) ?
                           10'h000 : din_mod + 10'd1;
            end
        end
    end

endmodule // ncsr_host

/* bench/ncsr_monitor.sv */
`timescale 1ns/1ps
module ncsr_monitor (
    // clock and reset
    input logic        CLOCK,
    input logic        RSTN,
    // apb
    input logic        PSEL,
    input logic        PENABLE,
    input logic        PWRITE,
    input logic [11:0] PADDR,
    input logic [31:0] PWDATA,
    input logic        PSLVERR,
    // flash bus
    input logic        CE_N,
    input logic        CLE,
    input logic        ALE,
    input logic        WE_N,
    input logic        RE_N,
    input logic [7:0]  IO_OUT,
    input logic        IO_OE
);
    default clocking @(posedge CLOCK); endclocking
    default disable iff (!RSTN);
    wire       go   = PSEL && PENABLE && PWRITE && PADDR == 12'h000 && !PSLVERR;
    wire [2:0] kind = PWDATA[10:8];
    property p_we; $fell(WE_N) |=> WE_N; endproperty
    a_we: assert property (p_we) else $error("write strobe too wide");
    property p_re; $fell(RE_N) |=> RE_N; endproperty
    a_re: assert property (p_re) else $error("read strobe too wide");
    property p_wr; !WE_N |-> !CE_N && RE_N && IO_OE && !(CLE && ALE); endproperty
    a_wr: assert property (p_wr) else $error("bad write cycle");
    property p_rd; !RE_N |-> !CE_N && WE_N && !CLE && !ALE && !IO_OE; endproperty
    a_rd: assert property (p_rd) else $error("bad read cycle");
    property p_hold; !WE_N |=> !CE_N && $stable(IO_OUT) && $stable(CLE) && $stable(ALE); endproperty
    a_hold: assert property (p_hold) else $error("bus moved at latch edge");
    property p_cmd; go && kind == 3'h0 |-> ##2 !WE_N && CLE && !ALE &&
        IO_OUT == $past(PWDATA[7:0], 2);
    endproperty
    a_cmd: assert property (p_cmd) else $error("command cycle wrong");
    property p_addr; go && kind == 3'h1 |-> ##2 !WE_N && ALE && !CLE; endproperty
    a_addr: assert property (p_addr) else $error("address cycle wrong");
    property p_dout; go && kind == 3'h3 |-> ##[1:5] $fell(RE_N); endproperty
    a_dout: assert property (p_dout) else $error("no read strobe");
endmodule // ncsr_monitor

bind ncsr_host ncsr_monitor u_ncsr_monitor (
    .CLOCK, .RSTN, .PSEL, .PENABLE, .PWRITE, .PADDR, .PWDATA, .PSLVERR,
    .CE_N, .CLE, .ALE, .WE_N, .RE_N, .IO_OUT, .IO_OE
);

/* bench/ncsr_dev_model.sv */
`timescale 1ns/1ps
module ncsr_dev_model #(
    parameter [39:0] ID_BYTES = 40'h5A3C109544, // arbitrary identity bytes
    parameter        BUSY_NS  = 2000
) (
    // strobes
    input  wire       ce_n,
    input  wire       cle,
    input  wire       ale,
    input  wire       we_n,
    input  wire       re_n,
    input  wire       wp_n,
    // bus and ready line
    input  wire [7:0] io_out,
    output reg  [7:0] io_in, // byte-wide only
    output reg        rb
);
    reg   [7:0] mode;
    reg   [2:0] idx;
    time        ready_at;
    initial begin
        rb       = 1'b1;
        io_in    = 8'h00;
        mode     = 8'hFF;
        idx      = 3'h0;
        ready_at = 0;
    end
    // a new deadline replaces the old one, so a reset cuts a long busy short
    always #1 if (!rb && $time >= ready_at) rb = 1'b1;
    always @(posedge we_n) if (!ce_n && cle && (rb || io_out == 8'h70 || io_out == 8'hFF)) begin
        if (io_out == 8'h35 || io_out == 8'h10) begin
            ready_at = $time + BUSY_NS;
            rb       = 1'b0;
        end
        if (io_out == 8'hFF && !(mode == 8'hFF && !rb)) begin
            ready_at = $time + BUSY_NS / 4;
            rb       = 1'b0;
        end
        idx  = 3'h0;
        mode = io_out;
    end
    // released bus never shows the held byte
    always @(posedge re_n) io_in = ~io_in;
    always @(negedge re_n) if (!ce_n && we_n && !cle && !ale) begin
        if (mode == 8'h70) io_in = {wp_n, rb, 6'h00};
        else if (mode == 8'h90) io_in = ID_BYTES[8 * (3'h4 - idx) +: 8];
        else if (mode == 8'h7B) io_in = 8'h00; // one combined flag, no error
        else io_in = ~io_in;
        idx = idx + 3'h1;
    end
endmodule // ncsr_dev_model

/* bench/tb_top.sv */
`timescale 1ns/1ps
`define CHK(a, e) begin tests_run++; if ((a) !== (e)) begin fail_count++; \
    $display("BAD %0t got %h want %h", $time, (a), (e)); end end
module tb_top;
    localparam [39:0] IDB = 40'h5A3C109544; // arbitrary identity bytes
    logic        clock = 1'b0, rstn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata, r;
    logic        pready, pslverr, ce_n, cle, ale, we_n, re_n, wp_n, io_oe, rb;
    logic [7:0]  io_out, io_in, a2;
    logic [32:0] e, m, exp_q[$], msk_q[$];
    int          fail_count = 0, tests_run = 0, n;
    always #12.5 clock = ~clock;
    ncsr_host u_ncsr_host (.CLOCK(clock), .RSTN(rstn), .PSEL(psel), .PENABLE(penable),
        .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready),
        .PSLVERR(pslverr), .CE_N(ce_n), .CLE(cle), .ALE(ale), .WE_N(we_n), .RE_N(re_n),
        .WP_N(wp_n), .IO_OUT(io_out), .IO_OE(io_oe), .IO_IN(io_in), .RB(rb));
    ncsr_dev_model #(.ID_BYTES(IDB)) u_ncsr_dev_model (.ce_n(ce_n), .cle(cle), .ale(ale),
        .we_n(we_n), .re_n(re_n), .wp_n(wp_n), .io_out(io_out), .io_in(io_in), .rb(rb));
    // each finished access takes the oldest note
    always @(posedge clock) if (psel && penable && pready) begin
        e = exp_q.pop_front();
        m = msk_q.pop_front();
        `CHK(({pslverr, prdata} ^ e) & m, 33'h0)
    end
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                       input logic [32:0] ex, input logic [32:0] mk);
        exp_q.push_back(ex);
        msk_q.push_back(mk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge clock);
        penable <= 1'b1;
        do @(posedge clock); while (pready !== 1'b1);
        r = prdata;
    endtask
    task automatic rd(input logic [11:0] a, input logic [32:0] ex);
        apb(1'b0, a, 32'h0, ex, 33'h1_FFFF_FFFF);
    endtask
    // one flash cycle, then poll busy
    task automatic fl(input logic [2:0] k, input logic [7:0] b);
        apb(1'b1, 12'h000, {21'h0, k, b}, 33'h0, 33'h1_0000_0000);
        do apb(1'b0, 12'h004, 32'h0, 33'h0, 33'h0); while (r[0] !== 1'b0);
    endtask
    task automatic conclude();
        if (fail_count == 0 && tests_run > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    initial begin
        repeat (60000) @(posedge clock);
        fail_count++;
        conclude();
    end
    initial begin
        n = $urandom(32'hB36AF080);
        repeat (12) @(posedge clock);
        rstn <= 1'b1;
        @(posedge clock);
        rd(12'h004, 33'h2);
        rd(12'h00C, 33'h0);
        rd(12'h010, 33'h1_0000_0000);
        apb(1'b1, 12'h00C, 32'h1, 33'h0, 33'h1_0000_0000);
        // second control write lands while busy
        apb(1'b1, 12'h000, 32'h70, 33'h0, 33'h1_0000_0000);
        apb(1'b1, 12'h000, 32'h70, 33'h1_0000_0000, 33'h1_0000_0000);
        fl(3'h0, 8'h70);
        repeat (2) begin
            fl(3'h3, 8'h00);
            rd(12'h008, 33'hC0);
        end
        fl(3'h0, 8'hFF);
        fl(3'h4, 8'h00);
        fl(3'h0, 8'h70);
        fl(3'h3, 8'h00);
        rd(12'h008, 33'hC0);
        fl(3'h0, 8'h90);
        fl(3'h1, 8'h00);
        for (n = 0; n < 5; n++) begin
            fl(3'h3, 8'h00);
            rd(12'h008, {25'h0, IDB[8 * (4 - n) +: 8]});
        end
        a2 = 8'($urandom);
        fl(3'h0, 8'h00);
        for (n = 0; n < 5; n++) fl(3'h1, n == 2 ? a2 : 8'($urandom));
        fl(3'h0, 8'h35);
        fl(3'h4, 8'h00);
        fl(3'h0, 8'h70);
        fl(3'h3, 8'h00);
        `CHK(u_ncsr_dev_model.mode, 8'h00)
        fl(3'h0, 8'h85);
        for (n = 0; n < 5; n++) fl(3'h1, n == 2 ? a2 ^ 8'h40 : 8'($urandom));
        n = $urandom_range(4, 1);
        repeat (n) fl(3'h2, 8'($urandom));
        fl(3'h0, 8'h10);
        fl(3'h4, 8'h00);
        rd(12'h004, 33'hE);
        apb(1'b1, 12'h004, 32'hC, 33'h0, 33'h1_0000_0000);
        rd(12'h004, 33'h2);
        fl(3'h0, 8'h70);
        fl(3'h3, 8'h00);
        rd(12'h008, 33'hC0);
        fl(3'h0, 8'h7B);
        fl(3'h3, 8'h00);
        rd(12'h008, 33'h0);
        psel    <= 1'b0;
        penable <= 1'b0;
        @(posedge clock);
        conclude();
    end
endmodule // tb_top
